// ### acs_capture_model.sv
// far-side capture logic: issues calibration request pulses on command
// assumes the bench pulses go for one cycle and keeps aclk running throughout
`timescale 1ns/1ps
module acs_capture_model (
  // clock
  input  wire logic       aclk,
  // command from the bench
  input  wire logic       go,
  input  wire logic [3:0] width,
  // pin towards the converter
  output logic            cal_req
);
  // no reset pin on this side, so the counter starts from its declared value
  logic [3:0] left_q = 4'h0;

  // a pulse narrower than two cycles could be lost in the pin synchroniser
  always_ff @(posedge aclk) begin
    if (go) begin
      left_q <= (width < 4'h2) ? 4'h2 : width;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end

  // clock is never gated here, so calibration always sees a running clock
  // the bench requests a fresh calibration as it would after a clock change
  assign cal_req = (left_q != 4'h0);
endmodule : acs_capture_model

// ### acs_pkg.sv
// constants, register map and state codes for the calibration sequencer
// assumes one 10 MHz clock domain and an AXI4-Lite master on the register side
// Operation
// - request rising edge clears the calibration correction register
// - calibration sequence starts on the request falling edge
// - whole sequence including output latency ends within 32,775 cycles
// - busy flag high for the sequence up to the seven-cycle output latency, low from then on
// - data outputs forced to zero while calibrating
// - analog inputs ignored while calibrating
// - first valid word seven cycles after busy falls
// - after power-on wait 2^21 cycles, then calibrate automatically
// - strap decode: reference gives 2Vp-p, ground 4Vp-p, supply external
// - format input high gives two's complement, low offset binary
// - output-float input high floats data outputs, low drives them
// - over-range flag travels with the data word of its sample
// - each sample is taken on the rising clock edge
package acs_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned DATA_W        = 14;
  localparam int unsigned CNT_W         = 22;
  localparam int unsigned ADDR_W        = 8;

  // cycle figures
  localparam int unsigned REQ_MIN_CYC   = 2;
  localparam int unsigned CAL_TOTAL_CYC = 32_775;
  localparam int unsigned VALID_LAT_CYC = 7;
  localparam int unsigned POR_CYC       = 2 ** 21;
  localparam int unsigned PIPE_LAT_CYC  = 6;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_INFO   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CORR   = 8'h0C;

  // event bits of status and mask
  localparam int unsigned EV_W         = 3;
  localparam int unsigned EV_CAL_START = 0;
  localparam int unsigned EV_CAL_DONE  = 1;
  localparam int unsigned EV_OVR       = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  // range strap level codes
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_REF = 2'h1;
  localparam logic [1:0] STRAP_SUP = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    ST_POR    = 5'h01,
    ST_RUN    = 5'h02,
    ST_ARM    = 5'h04,
    ST_CAL    = 5'h08,
    ST_SETTLE = 5'h10
  } acs_state_e;

endpackage : acs_pkg

// ### acs_top.sv
// calibration sequencer, output formatting and register slave of the converter
// assumes pins pass through two flops; sample and trim words share aclk
`timescale 1ns/1ps
module acs_top #(
  parameter int unsigned POR_CYCLES = acs_pkg::POR_CYC,
  parameter int unsigned CAL_CYCLES = acs_pkg::CAL_TOTAL_CYC
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write
  input  wire logic [acs_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [acs_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // control pins
  input  wire logic                        cal_req,
  input  wire logic                        twos_complement_select,
  input  wire logic                        output_float,
  input  wire logic [1:0]                  range_strap,
  // converter core
  input  wire logic [acs_pkg::DATA_W-1:0]  sample_word,
  input  wire logic                        sample_over,
  input  wire logic [acs_pkg::DATA_W-1:0]  cal_trim,
  output logic                             input_enable,
  output logic                             ref_internal_on,
  output logic                             range_4v,
  // data side
  output logic [acs_pkg::DATA_W-1:0]       data_out,
  output logic                             data_oe_n,
  output logic                             over_range_flag,
  output logic                             cal_busy,
  output logic                             irq
);

  localparam int unsigned DW       = acs_pkg::DATA_W;
  localparam int unsigned PL       = acs_pkg::PIPE_LAT_CYC;
  localparam int unsigned BUSY_CYC = CAL_CYCLES - acs_pkg::VALID_LAT_CYC;
  localparam int          VLAST    = acs_pkg::VALID_LAT_CYC - 1;

  function automatic logic [DW-1:0] fmt_word(input logic [DW-1:0] w, input logic twos);
    fmt_word = twos ? {~w[DW-1], w[DW-2:0]} : w;
  endfunction : fmt_word

  // pin synchronisers: cal_req, format, float, strap[1:0]
  logic [4:0] sync1_q, sync2_q;
  logic       req3_q;
  logic       rise_w, fall_w;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      req3_q  <= 1'b0;
    end else begin
      sync1_q <= {range_strap, output_float, twos_complement_select, cal_req};
      sync2_q <= sync1_q;
      req3_q  <= sync2_q[0];
    end
  end
  assign rise_w = sync2_q[0] & ~req3_q;
  assign fall_w = ~sync2_q[0] & req3_q;

  // sequencer
  acs_pkg::acs_state_e state_q, state_d;
  logic [acs_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [DW-1:0]             corr_q, corr_d;
  logic                      ev_start, ev_done;
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q + 1'b1;
    corr_d   = corr_q;
    ev_start = 1'b0;
    ev_done  = 1'b0;
    if (rise_w) begin
      state_d = acs_pkg::ST_ARM;
      corr_d  = '0;
      cnt_d   = '0;
    end else begin
      case (state_q)
        acs_pkg::ST_POR: begin
          if (cnt_q == acs_pkg::CNT_W'(POR_CYCLES - 1)) begin
            state_d  = acs_pkg::ST_CAL;
            cnt_d    = '0;
            ev_start = 1'b1;
          end
        end
        acs_pkg::ST_RUN: begin
          cnt_d = '0;
        end
        acs_pkg::ST_ARM: begin
          cnt_d = '0;
          if (fall_w) begin
            state_d  = acs_pkg::ST_CAL;
            ev_start = 1'b1;
          end
        end
        acs_pkg::ST_CAL: begin
          if (cnt_q == acs_pkg::CNT_W'(BUSY_CYC - 1)) begin
            state_d = acs_pkg::ST_SETTLE;
            cnt_d   = '0;
            corr_d  = cal_trim;
          end
        end
        acs_pkg::ST_SETTLE: begin
          if (cnt_q == acs_pkg::CNT_W'(VLAST)) begin
            state_d = acs_pkg::ST_RUN;
            cnt_d   = '0;
            ev_done = 1'b1;
          end
        end
        default: begin
          state_d = acs_pkg::ST_POR;
          cnt_d   = '0;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= acs_pkg::ST_POR;
      cnt_q   <= '0;
      corr_q  <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      corr_q  <= corr_d;
    end
  end

  // conversion pipeline: {over, word} per stage
  logic [DW:0] pipe_q [PL];
  logic [DW:0] pipe_d [PL];
  logic        in_en_d;
  always_comb begin
    // armed or calibrating: analog side is disconnected
    in_en_d = (state_d != acs_pkg::ST_ARM) && (state_d != acs_pkg::ST_CAL);
    pipe_d[0] = in_en_d ? {sample_over, DW'(sample_word + corr_q)} : '0;
    for (int i = 1; i < PL; i++) begin
      pipe_d[i] = pipe_q[i-1];
    end
  end
  always_ff @(posedge aclk) begin
    for (int i = 0; i < PL; i++) begin
      if (!aresetn) begin
        pipe_q[i] <= '0;
      end else begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  // outputs and strap capture
  logic [DW-1:0] data_d;
  logic          ovr_d, busy_d, valid_d;
  logic          strap_done_q, ref_int_d, range4_d, strap_done_d;
  always_comb begin
    valid_d = (state_d == acs_pkg::ST_RUN);
    busy_d  = (state_d == acs_pkg::ST_CAL);
    data_d  = valid_d ? fmt_word(pipe_q[PL-1][DW-1:0], sync2_q[1]) : '0;
    ovr_d   = valid_d & pipe_q[PL-1][DW];
    ref_int_d    = ref_internal_on;
    range4_d     = range_4v;
    strap_done_d = strap_done_q;
    // strap is sampled once, after the synchroniser has filled
    if (!strap_done_q && cnt_q == acs_pkg::CNT_W'(acs_pkg::REQ_MIN_CYC)) begin
      strap_done_d = 1'b1;
      ref_int_d    = (sync2_q[4:3] != acs_pkg::STRAP_SUP);
      range4_d     = (sync2_q[4:3] == acs_pkg::STRAP_GND);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out        <= '0;
      over_range_flag <= 1'b0;
      cal_busy        <= 1'b0;
      input_enable    <= 1'b1;
      data_oe_n       <= 1'b1;
      strap_done_q    <= 1'b0;
      ref_internal_on <= 1'b1;
      range_4v        <= 1'b0;
    end else begin
      data_out        <= data_d;
      over_range_flag <= ovr_d;
      cal_busy        <= busy_d;
      input_enable    <= in_en_d;
      data_oe_n       <= sync2_q[2];
      strap_done_q    <= strap_done_d;
      ref_internal_on <= ref_int_d;
      range_4v        <= range4_d;
    end
  end

  // register slave
  logic [acs_pkg::EV_W-1:0]   status_q, status_d, mask_q, mask_d, ev_w;
  logic                       awh_q, awh_d, wh_q, wh_d, bv_d, awr_d, wr_d;
  logic [acs_pkg::ADDR_W-1:0] awa_q, awa_d;
  logic [31:0]                wd_q, wd_d, rd_d;
  logic [3:0]                 ws_q, ws_d;
  logic [1:0]                 br_d, rr_d;
  logic                       rv_d, arr_d, do_wr, irq_d;
  always_comb begin
    ev_w = '0;
    ev_w[acs_pkg::EV_CAL_START] = ev_start;
    ev_w[acs_pkg::EV_CAL_DONE]  = ev_done;
    ev_w[acs_pkg::EV_OVR]       = ovr_d & ~over_range_flag;
    awh_d = awh_q | (s_axi_awvalid & s_axi_awready);
    awa_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_q;
    wh_d  = wh_q | (s_axi_wvalid & s_axi_wready);
    wd_d  = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_q;
    ws_d  = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : ws_q;
    bv_d  = s_axi_bvalid & ~s_axi_bready;
    br_d  = s_axi_bresp;
    do_wr = awh_d & wh_d & ~bv_d;
    status_d = status_q;
    mask_d   = mask_q;
    if (do_wr) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = acs_pkg::RESP_OKAY;
      case (awa_d)
        acs_pkg::REG_STATUS: begin
          if (ws_d[0]) status_d = status_q & ~wd_d[acs_pkg::EV_W-1:0];
        end
        acs_pkg::REG_MASK: begin
          if (ws_d[0]) mask_d = wd_d[acs_pkg::EV_W-1:0];
        end
        acs_pkg::REG_INFO, acs_pkg::REG_CORR: begin
          br_d = acs_pkg::RESP_OKAY;
        end
        default: begin
          br_d = acs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    status_d = status_d | ev_w;
    irq_d    = |(status_d & mask_d);
    awr_d    = ~awh_d & ~bv_d;
    wr_d     = ~wh_d & ~bv_d;
    rv_d     = s_axi_rvalid & ~s_axi_rready;
    rd_d     = s_axi_rdata;
    rr_d     = s_axi_rresp;
    if (s_axi_arvalid & s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = acs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        acs_pkg::REG_STATUS: rd_d = 32'(status_q);
        acs_pkg::REG_MASK:   rd_d = 32'(mask_q);
        acs_pkg::REG_INFO:   rd_d = 32'({strap_done_q, range_4v, ref_internal_on,
                                         cal_busy, state_q});
        acs_pkg::REG_CORR:   rd_d = 32'(corr_q);
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = acs_pkg::RESP_SLVERR;
        end
      endcase
    end
    arr_d = ~rv_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q      <= acs_pkg::EV_RESET;
      mask_q        <= acs_pkg::EV_RESET;
      awh_q         <= 1'b0;
      wh_q          <= 1'b0;
      awa_q         <= '0;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acs_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= acs_pkg::RESP_OKAY;
      irq           <= 1'b0;
    end else begin
      status_q      <= status_d;
      mask_q        <= mask_d;
      awh_q         <= awh_d;
      wh_q          <= wh_d;
      awa_q         <= awa_d;
      wd_q          <= wd_d;
      ws_q          <= ws_d;
      s_axi_awready <= awr_d;
      s_axi_wready  <= wr_d;
      s_axi_bvalid  <= bv_d;
      s_axi_bresp   <= br_d;
      s_axi_arready <= arr_d;
      s_axi_rvalid  <= rv_d;
      s_axi_rdata   <= rd_d;
      s_axi_rresp   <= rr_d;
      irq           <= irq_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  corr_clear_a: assert property (rise_w |=> corr_q == '0)
    else $error("correction not cleared on request rise");
  arm_hold_a: assert property ((state_q == acs_pkg::ST_ARM) && !fall_w && !rise_w
    |=> (state_q == acs_pkg::ST_ARM) && !cal_busy)
    else $error("calibration started before request fell");
  busy_bound_a: assert property (cal_busy |-> cnt_q < BUSY_CYC)
    else $error("calibration ran too long");
  busy_state_a: assert property (cal_busy == (state_q == acs_pkg::ST_CAL))
    else $error("busy flag does not match sequence");
  zero_out_a: assert property (cal_busy |-> data_out == '0 && !over_range_flag)
    else $error("data not zero during calibration");
  input_off_a: assert property (cal_busy |-> !input_enable && pipe_q[0] == '0)
    else $error("analog input used during calibration");
  valid_lat_a: assert property ((state_q == acs_pkg::ST_SETTLE) && cnt_q == VLAST
    && !rise_w |=> (state_q == acs_pkg::ST_RUN) && $past(data_out == '0))
    else $error("first valid word not seven cycles after busy");
  por_cal_a: assert property ((state_q == acs_pkg::ST_POR)
    && cnt_q == acs_pkg::CNT_W'(POR_CYCLES - 1) && !rise_w |=> cal_busy)
    else $error("power-on calibration did not start");
  float_out_a: assert property ($past(aresetn) |-> data_oe_n == $past(sync2_q[2]))
    else $error("output float not followed");

  busy_rise_c: cover property ($rose(cal_busy));
  demand_cal_c: cover property ((state_q == acs_pkg::ST_ARM) ##1 cal_busy);
  cal_done_c: cover property ($fell(cal_busy) ##7 (state_q == acs_pkg::ST_RUN));

endmodule : acs_top

// ### acs_top_test.sv
// self-checking bench for the calibration sequencer
// assumes shortened power-on and calibration counts passed as parameters
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end
module acs_top_test;
  localparam int unsigned POR_C = 64;
  localparam int unsigned CAL_C = 40;
  logic        aclk, aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, cal_req, twos_complement_select;
  logic        output_float, sample_over, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, input_enable, ref_internal_on, range_4v;
  logic        data_oe_n, over_range_flag, cal_busy, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, width;
  logic [1:0]  s_axi_bresp, s_axi_rresp, range_strap, rsp;
  logic [13:0] sample_word, cal_trim, data_out;
  int          miscompares, n_tests, i, n;
  logic [1:0]  strap_tab [3] = '{acs_pkg::STRAP_SUP, acs_pkg::STRAP_REF, acs_pkg::STRAP_GND};
  logic        r4v_tab [3] = '{1'b0, 1'b0, 1'b1};
  logic        ref_tab [3] = '{1'b0, 1'b1, 1'b1};

  acs_top #(.POR_CYCLES(POR_C), .CAL_CYCLES(CAL_C)) acs_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cal_req, .twos_complement_select, .output_float,
    .range_strap, .sample_word, .sample_over, .cal_trim, .input_enable, .ref_internal_on,
    .range_4v, .data_out, .data_oe_n, .over_range_flag, .cal_busy, .irq);

  acs_capture_model acs_capture_model_inst (.aclk, .go, .width, .cal_req);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task tmo;
    miscompares++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    end_sim;
  endtask : tmo

  task cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !(aw_ok && w_ok); i++) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w_ok && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    if (!(aw_ok && w_ok)) tmo;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge aclk);
    if (i == 50) tmo;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) break;
    end
    if (i == 50) tmo;
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) @(posedge aclk);
    if (i == 50) tmo;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // waits for cal_busy to reach v, returns edges spent in n
  task wait_busy(input logic v, input int lim);
    for (n = 0; n < lim && cal_busy !== v; n++) @(posedge aclk);
    if (n == lim) tmo;
  endtask : wait_busy

  initial begin
    {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, twos_complement_select, output_float, sample_over} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, width} = '0;
    range_strap = acs_pkg::STRAP_GND;
    sample_word = 14'h0123;
    cal_trim = 14'h0010;
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      aresetn <= 1'b0;
      range_strap <= strap_tab[k];
      cyc(16);
      `CHECK_EQ(data_oe_n, 1'b1)
      `CHECK_EQ(cal_busy, 1'b0)
      aresetn <= 1'b1;
      cyc(8);
      `CHECK_EQ(ref_internal_on, ref_tab[k])
      `CHECK_EQ(range_4v, r4v_tab[k])
    end
    $display("test strap decode done");

    wait_busy(1'b1, POR_C + 10);
    `CHECK_EQ(n, POR_C - 7)
    for (n = 0; n < 60 && cal_busy === 1'b1; n++) begin
      `CHECK_EQ(data_out, 14'h0000)
      `CHECK_EQ(input_enable, 1'b0)
      @(posedge aclk);
    end
    `CHECK_EQ(n, CAL_C - 7)
    for (n = 0; n < 20 && data_out === 14'h0000; n++) @(posedge aclk);
    `CHECK_EQ(n, 7)
    `CHECK_EQ(data_out, 14'h0133)
    `CHECK_EQ(input_enable, 1'b1)
    $display("test power-on calibration done");

    axi_rd(acs_pkg::REG_STATUS, rd, rsp);
    `CHECK_EQ(rd, 32'h0000_0003)
    `CHECK_EQ(irq, 1'b0)
    axi_wr(acs_pkg::REG_MASK, 32'h0000_0002, rsp);
    `CHECK_EQ(rsp, acs_pkg::RESP_OKAY)
    cyc(2);
    `CHECK_EQ(irq, 1'b1)
    axi_wr(acs_pkg::REG_STATUS, 32'h0000_0002, rsp);
    cyc(2);
    `CHECK_EQ(irq, 1'b0)
    axi_rd(8'h40, rd, rsp);
    `CHECK_EQ(rsp, acs_pkg::RESP_SLVERR)
    `CHECK_EQ(rd, 32'h0000_0000)
    $display("test registers and interrupt done");

    cal_trim <= 14'h0020;
    go <= 1'b1;
    width <= 4'h5;
    @(posedge aclk);
    go <= 1'b0;
    for (int c = 0; c < 7; c++) begin
      @(posedge aclk);
      `CHECK_EQ(cal_busy, 1'b0)
    end
    wait_busy(1'b1, 8);
    axi_rd(acs_pkg::REG_CORR, rd, rsp);
    `CHECK_EQ(rd, 32'h0000_0000)
    wait_busy(1'b0, 60);
    cyc(8);
    axi_rd(acs_pkg::REG_CORR, rd, rsp);
    `CHECK_EQ(rd, 32'h0000_0020)
    `CHECK_EQ(data_out, 14'h0143)
    go <= 1'b1;
    width <= 4'h2;
    @(posedge aclk);
    go <= 1'b0;
    wait_busy(1'b1, 12);
    wait_busy(1'b0, 60);
    cyc(8);
    $display("test demand calibration done");

    twos_complement_select <= 1'b1;
    cyc(6);
    `CHECK_EQ(data_out, 14'h2143)
    twos_complement_select <= 1'b0;
    sample_word <= 14'h0200;
    sample_over <= 1'b1;
    // the word returns to its offset binary form before the new sample lands
    for (n = 0; n < 20 && (data_out === 14'h0143 || data_out === 14'h2143); n++) @(posedge aclk);
    `CHECK_EQ(data_out, 14'h0220)
    `CHECK_EQ(over_range_flag, 1'b1)
    output_float <= 1'b1;
    cyc(5);
    `CHECK_EQ(data_oe_n, 1'b1)
    output_float <= 1'b0;
    cyc(5);
    `CHECK_EQ(data_oe_n, 1'b0)
    $display("test data path done");
    end_sim;
  end
endmodule : acs_top_test
